// ===== verilog/rbs_params.svh
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH

// receive output mode codes
`define RBS_MODE_RAW        2'h0
`define RBS_MODE_DEGLITCH   2'h1
`define RBS_MODE_RECOVER    2'h2
`define RBS_MODE_TRAIN      2'h3

// first prescaler codes select divide by 1, 5, 6 or 8
`define RBS_DIV_A_CODE0     4'h1
`define RBS_DIV_A_CODE1     4'h5
`define RBS_DIV_A_CODE2     4'h6
`define RBS_DIV_A_CODE3     4'h8

// oversample divider choices
`define RBS_DIV_C_LOW       5'hf
`define RBS_DIV_C_HIGH      5'h10

// deglitch window and vote thresholds
`define RBS_DG_WINDOW       7
`define RBS_DG_HIGH_VOTES   4'h5
`define RBS_DG_LOW_VOTES    4'h2

// training length equation terms
`define RBS_TRAIN_MULT      8'h4
`define RBS_TRAIN_BASE      8'h2

// reset value of the demodulator trim output
`define RBS_TRIM_RESET      3'h6

`endif

// ===== verilog/rbs_pkg.sv
package rbs_pkg;

   // receive output mode
   typedef enum logic [1:0] {
      RBS_RAW,
      RBS_DEGLITCH,
      RBS_RECOVER,
      RBS_TRAIN
   } rbs_mode_t;

   // one recovered bit with its end-of-training mark
   typedef struct packed {
      logic train_end;
      logic data_bit;
   } rbs_bit_t;

endpackage : rbs_pkg

// ===== verilog/rbs_bit_buffer.sv
module rbs_bit_buffer
   import rbs_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             clear_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);

   logic [WIDTH-1:0] mem_reg [2];
   logic             wr_ptr_reg;
   logic             rd_ptr_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   ////////////////////////////////////////////////////////////////////////
   // handshakes
   assign in_ready_out  = (count_reg != 2'h2);
   assign out_valid_out = (count_reg != 2'h0);
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign out_data_out  = mem_reg[rd_ptr_reg];

   ////////////////////////////////////////////////////////////////////////
   // storage, cleared by reset, otherwise written only on push
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   // pointers and fill count
   always_ff @(posedge clock_in) begin
      if (!rst_n_in || clear_in) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   a_buf_no_overfill : assert property (@(posedge clock_in)
      disable iff (!rst_n_in) count_reg <= 2'h2)
      else $error("bit buffer count above two");

endmodule : rbs_bit_buffer

// ===== verilog/rbs_bit_sync.sv
// Functional notes
// - mode 00 puts the slicer level on the data output with no filtering.
// - mode 01 puts the deglitched slicer level on the data output.
// - modes 10 and 11 output recovered bits with a matching bit clock.
// - bit rate is master clock over the product of the three dividers.
// - divider codes only reach 1/5/6/8, powers of two to 128, 15 or 16.
// - the bit clock runs at the bit rate only in modes 10 and 11.
// - with on-off keying the detector level replaces the slicer level.
// - learn closes the threshold switch, hold opens it.
// - deglitch votes five of seven high, two or fewer low, else holds.
// - in modes 10 and 11 data changes on the falling bit clock, clock low until a data edge.
// - training end pulses for one bit clock at the first breaking bit.
// - minimum training bits are four times the field, plus two, plus pair.
`include "rbs_params.svh"

module rbs_bit_sync
   import rbs_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       slicer_in,
   input  wire logic       detector_in,
   input  wire logic       ook_select_in,
   input  wire logic [1:0] rx_output_mode_field_in,
   input  wire logic [1:0] prescale_div_a_in,
   input  wire logic [2:0] prescale_div_b_in,
   input  wire logic       bit_oversample_div_in,
   input  wire logic       paired_training_select_in,
   input  wire logic [4:0] training_length_field_in,
   input  wire logic       threshold_track_hold_in,
   input  wire logic [2:0] discriminator_trim_in,
   input  wire logic       bit_ready_in,
   output logic            received_bit_out,
   output logic            recovered_bit_clock_out,
   output logic            training_end_flag_out,
   output logic            threshold_learn_out,
   output logic            detector_bypass_out,
   output logic [2:0]      discriminator_trim_out,
   output logic            bit_valid_out,
   output rbs_bit_t        bit_word_out,
   output logic            bit_accept_out
);

   rbs_mode_t   mode;
   logic [1:0]  mode_prev_reg;
   logic        restart;
   logic [1:0]  slicer_sync_reg;
   logic [1:0]  detector_sync_reg;
   logic        src_bit;
   logic [3:0]  div_a;
   logic [7:0]  div_b;
   logic [4:0]  div_c;
   logic [11:0] pre_total;
   logic [11:0] pre_cnt_reg;
   logic        tick;
   logic [`RBS_DG_WINDOW-1:0] dg_shift_reg;
   logic [`RBS_DG_WINDOW-1:0] dg_shift_next;
   logic [3:0]  votes;
   logic        dg_reg;
   logic        dg_next;
   logic        edge_seen;
   logic [4:0]  phase_reg;
   logic [4:0]  half_c;
   logic        seen_edge_reg;
   logic        bit_strobe;
   logic        prev1_reg;
   logic        prev2_reg;
   logic [1:0]  hist_cnt_reg;
   logic        bit_fits;
   logic [7:0]  train_cnt_reg;
   logic [7:0]  train_min;
   logic        flag_reg;
   logic        rx_bit_reg;
   logic        recovered_bit_clock_reg;
   logic        recovered_bit_clock_next;
   rbs_bit_t    push_word;

   ////////////////////////////////////////////////////////////////////////
   // mode decode and restart on change
   assign mode    = rbs_mode_t'(rx_output_mode_field_in);
   assign restart = (mode_prev_reg != rx_output_mode_field_in);

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         mode_prev_reg <= `RBS_MODE_RAW;
      end else begin
         mode_prev_reg <= rx_output_mode_field_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, second stage only is read
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         slicer_sync_reg   <= 2'h0;
         detector_sync_reg <= 2'h0;
      end else begin
         slicer_sync_reg   <= {slicer_sync_reg[0], slicer_in};
         detector_sync_reg <= {detector_sync_reg[0], detector_in};
      end
   end

   // on-off keying takes the detector path
   assign src_bit = ook_select_in ? detector_sync_reg[1]
                                  : slicer_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // analog side controls
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         threshold_learn_out    <= 1'b0;
         detector_bypass_out    <= 1'b0;
         discriminator_trim_out <= `RBS_TRIM_RESET;
      end else begin
         threshold_learn_out    <= threshold_track_hold_in;
         detector_bypass_out    <= ook_select_in;
         discriminator_trim_out <= discriminator_trim_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // divider code decode, only legal values reachable
   always_comb begin
      unique case (prescale_div_a_in)
         2'h0: div_a = `RBS_DIV_A_CODE0;
         2'h1: div_a = `RBS_DIV_A_CODE1;
         2'h2: div_a = `RBS_DIV_A_CODE2;
         2'h3: div_a = `RBS_DIV_A_CODE3;
      endcase
   end

   assign div_b     = 8'h1 << prescale_div_b_in;
   assign div_c     = bit_oversample_div_in ? `RBS_DIV_C_HIGH
                                            : `RBS_DIV_C_LOW;
   assign pre_total = 12'(div_a * div_b);
   assign half_c    = div_c >> 1;

   // prescaler, one tick every div_a times div_b cycles
   always_ff @(posedge clock_in) begin
      if (!rst_n_in || restart) begin
         pre_cnt_reg <= 12'h0;
      end else if (pre_cnt_reg >= pre_total - 12'h1) begin
         pre_cnt_reg <= 12'h0;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 12'h1;
      end
   end

   assign tick = (pre_cnt_reg >= pre_total - 12'h1) && !restart;

   ////////////////////////////////////////////////////////////////////////
   // deglitch vote over the sample window
   assign dg_shift_next = {dg_shift_reg[`RBS_DG_WINDOW-2:0], src_bit};

   always_comb begin
      votes = 4'h0;
      for (int i = 0; i < `RBS_DG_WINDOW; i++) begin
         votes = votes + {3'h0, dg_shift_next[i]};
      end
   end

   always_comb begin
      if (votes >= `RBS_DG_HIGH_VOTES) begin
         dg_next = 1'b1;
      end else if (votes <= `RBS_DG_LOW_VOTES) begin
         dg_next = 1'b0;
      end else begin
         dg_next = dg_reg;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in || restart) begin
         dg_shift_reg <= '0;
         dg_reg       <= 1'b0;
      end else if (tick) begin
         dg_shift_reg <= dg_shift_next;
         dg_reg       <= dg_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit phase, realigned on each deglitched data edge
   assign edge_seen  = tick && (dg_next != dg_reg);
   assign bit_strobe = tick && !edge_seen && seen_edge_reg
                       && (phase_reg == half_c - 5'h1);

   always_ff @(posedge clock_in) begin
      if (!rst_n_in || restart) begin
         phase_reg     <= 5'h0;
         seen_edge_reg <= 1'b0;
      end else if (edge_seen) begin
         phase_reg     <= 5'h0;
         seen_edge_reg <= 1'b1;
      end else if (tick) begin
         if (phase_reg >= div_c - 5'h1) begin
            phase_reg <= 5'h0;
         end else begin
            phase_reg <= phase_reg + 5'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // training pattern tracking on each recovered bit
   // in paired mode the second bit received cannot break the pattern yet, so it counts
   assign bit_fits = paired_training_select_in
                     ? (hist_cnt_reg == 2'h1)
                       || ((hist_cnt_reg == 2'h2) && (dg_reg != prev2_reg))
                     : (hist_cnt_reg != 2'h0) && (dg_reg != prev1_reg);
   assign train_min = `RBS_TRAIN_MULT * {3'h0, training_length_field_in}
                      + `RBS_TRAIN_BASE
                      + {7'h0, paired_training_select_in};

   always_ff @(posedge clock_in) begin
      if (!rst_n_in || restart) begin
         prev1_reg    <= 1'b0;
         prev2_reg    <= 1'b0;
         hist_cnt_reg <= 2'h0;
      end else if (bit_strobe) begin
         prev1_reg <= dg_reg;
         prev2_reg <= prev1_reg;
         if (hist_cnt_reg != 2'h2) begin
            hist_cnt_reg <= hist_cnt_reg + 2'h1;
         end
      end
   end

   // pattern length count, saturating
   always_ff @(posedge clock_in) begin
      if (!rst_n_in || restart) begin
         train_cnt_reg <= 8'h0;
      end else if (bit_strobe) begin
         if (bit_fits || hist_cnt_reg == 2'h0) begin
            if (train_cnt_reg != 8'hff) begin
               train_cnt_reg <= train_cnt_reg + 8'h1;
            end
         end else begin
            train_cnt_reg <= 8'h0;
         end
      end
   end

   // end flag, one bit clock long, self train mode only
   always_ff @(posedge clock_in) begin
      if (!rst_n_in || restart) begin
         flag_reg <= 1'b0;
      end else if (bit_strobe) begin
         flag_reg <= (mode == RBS_TRAIN) && !bit_fits
                     && (hist_cnt_reg != 2'h0)
                     && (train_cnt_reg >= train_min);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output selection per mode
   always_comb begin
      unique case (mode)
         RBS_RAW: begin
            recovered_bit_clock_next = 1'b0;
         end
         RBS_DEGLITCH: begin
            recovered_bit_clock_next = (pre_cnt_reg < (pre_total >> 1))
                        || (pre_total == 12'h1);
         end
         RBS_RECOVER, RBS_TRAIN: begin
            recovered_bit_clock_next = seen_edge_reg && (phase_reg >= half_c);
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rx_bit_reg <= 1'b0;
         recovered_bit_clock_reg   <= 1'b0;
      end else begin
         if (mode == RBS_RAW) begin
            rx_bit_reg <= src_bit;
         end else begin
            rx_bit_reg <= dg_reg;
         end
         recovered_bit_clock_reg <= recovered_bit_clock_next && !restart;
      end
   end

   assign received_bit_out        = rx_bit_reg;
   assign recovered_bit_clock_out = recovered_bit_clock_reg;
   assign training_end_flag_out   = flag_reg;

   ////////////////////////////////////////////////////////////////////////
   // recovered bits toward the host through a two entry buffer
   assign push_word.train_end = (mode == RBS_TRAIN) && !bit_fits
                                && (hist_cnt_reg != 2'h0)
                                && (train_cnt_reg >= train_min);
   assign push_word.data_bit  = dg_reg;

   rbs_bit_buffer #(
      .WIDTH ($bits(rbs_bit_t))
   ) u_buffer (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .clear_in      (restart),
      .in_valid_in   (bit_strobe && mode[1]),
      .in_data_in    (push_word),
      .in_ready_out  (bit_accept_out),
      .out_valid_out (bit_valid_out),
      .out_data_out  (bit_word_out),
      .out_ready_in  (bit_ready_in)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_raw_passes_slicer : assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (mode == RBS_RAW) |=> received_bit_out == $past(src_bit))
      else $error("raw mode output not slicer level");

   a_raw_clock_low : assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (mode == RBS_RAW) ##1 (mode == RBS_RAW)
      |-> !recovered_bit_clock_out && !training_end_flag_out)
      else $error("clock or flag active in raw mode");

   a_deglitch_output : assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (mode == RBS_DEGLITCH) |=> received_bit_out == $past(dg_reg))
      else $error("deglitch mode output not filtered");

   a_vote_high : assert property (@(posedge clock_in)
      disable iff (!rst_n_in || restart)
      tick && votes >= 4'h5 |=> dg_reg)
      else $error("five votes did not drive filter high");

   a_vote_low : assert property (@(posedge clock_in)
      disable iff (!rst_n_in || restart)
      tick && votes <= 4'h2 |=> !dg_reg)
      else $error("two votes did not drive filter low");

   a_clock_waits_edge : assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      !seen_edge_reg && mode[1] |=> !recovered_bit_clock_out)
      else $error("bit clock ran before a data edge");

   a_edge_falls_clock : assert property (@(posedge clock_in)
      disable iff (!rst_n_in || restart)
      edge_seen && mode[1] |=> ##1 !recovered_bit_clock_out)
      else $error("data edge not on falling bit clock");

   a_flag_train_only : assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      training_end_flag_out |-> $past(mode) == RBS_TRAIN)
      else $error("training flag outside self train");

   a_flag_needs_length : assert property (@(posedge clock_in)
      disable iff (!rst_n_in || restart)
      bit_strobe && train_cnt_reg < train_min |=> !flag_reg)
      else $error("training flag before minimum length");

   a_restart_clears : assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      restart |=> !seen_edge_reg && !flag_reg && phase_reg == 5'h0)
      else $error("mode change left stale state");

   a_phase_bound : assert property (@(posedge clock_in)
      disable iff (!rst_n_in || restart)
      phase_reg < div_c)
      else $error("bit phase beyond oversample divider");

   c_recovered_bit : cover property (@(posedge clock_in)
      disable iff (!rst_n_in) bit_strobe && mode == RBS_RECOVER);

   c_training_end : cover property (@(posedge clock_in)
      disable iff (!rst_n_in) $rose(training_end_flag_out));

   c_buffer_full : cover property (@(posedge clock_in)
      disable iff (!rst_n_in) !bit_accept_out);

endmodule : rbs_bit_sync

// ===== tb/rbs_host_model.sv
module rbs_host_model
   import rbs_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   input  wire logic stall_in,
   input  wire logic slow_in,
   output logic      bit_ready_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [1:0] pace_reg;

   // host takes a bit every cycle, one cycle in four, or none
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pace_reg      <= 2'h0;
         bit_ready_out <= 1'b0;
      end else begin
         pace_reg      <= pace_reg + 2'h1;
         bit_ready_out <= !stall_in && (!slow_in || pace_reg == 2'h3);
      end
   end
endmodule : rbs_host_model

// ===== tb/rx_bit_synchronizer_tb.sv
module rx_bit_synchronizer_tb
   import rbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk, rst_n, slicer, detector, ook, pair, learn, div_c;
   logic       stall, slow, ready, rx_bit, recovered_bit_clock, tflag, learn_o, bypass;
   logic       bvalid, baccept, rx_q;
   logic [1:0] mode, mode_q, div_a;
   logic [2:0] div_b, trim, trim_o;
   logic [4:0] tlen;
   rbs_bit_t   bword;
   logic       exp_q[$];
   int         n_errors, checked, fcnt, ecnt;

   ////////////////////////////////////////////////////////////////////
   rbs_bit_sync i_dut (
      .clock_in                  (clk),
      .rst_n_in                  (rst_n),
      .slicer_in                 (slicer),
      .detector_in               (detector),
      .ook_select_in             (ook),
      .rx_output_mode_field_in   (mode),
      .prescale_div_a_in         (div_a),
      .prescale_div_b_in         (div_b),
      .bit_oversample_div_in     (div_c),
      .paired_training_select_in (pair),
      .training_length_field_in  (tlen),
      .threshold_track_hold_in   (learn),
      .discriminator_trim_in     (trim),
      .bit_ready_in              (ready),
      .received_bit_out          (rx_bit),
      .recovered_bit_clock_out   (recovered_bit_clock),
      .training_end_flag_out     (tflag),
      .threshold_learn_out       (learn_o),
      .detector_bypass_out       (bypass),
      .discriminator_trim_out    (trim_o),
      .bit_valid_out             (bvalid),
      .bit_word_out              (bword),
      .bit_accept_out            (baccept)
   );

   rbs_host_model i_host (
      .clock_in      (clk),
      .rst_n_in      (rst_n),
      .stall_in      (stall),
      .slow_in       (slow),
      .bit_ready_out (ready)
   );

   ////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [15:0] got, exp, input string msg);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wait_lvl(input logic v, input int lim, output int k);
      for (k = 0; k < lim && recovered_bit_clock !== v; k++) @(negedge clk);
      if (recovered_bit_clock !== v) begin
         n_errors++;
         $display("unexpected at %0t: bit clock wait timed out", $time);
         tally_and_finish();
      end
   endtask : wait_lvl

   task automatic send_bit(input logic b, input int per, input logic note);
      @(posedge clk);
      slicer <= b;
      if (note) exp_q.push_back(b);
      repeat (per) begin
         @(negedge clk);
         if (tflag === 1'b1) fcnt++;
      end
   endtask : send_bit

   task automatic glitch(input logic base, input int w, input logic flips);
      logic saw;
      saw = 1'b0;
      @(posedge clk);
      slicer <= ~base;
      cyc(w);
      slicer <= base;
      repeat (20) begin
         @(negedge clk);
         if (rx_bit !== base) saw = 1'b1;
      end
      check(16'(saw), 16'(flips), "deglitch vote");
   endtask : glitch

   // clock source
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // pops are compared with the oldest noted bit; data moves on low clock
   always @(negedge clk) begin
      if (rst_n === 1'b1 && bvalid === 1'b1 && ready === 1'b1
          && bword.train_end === 1'b1)
         ecnt++;
      if (rst_n === 1'b1 && bvalid === 1'b1 && ready === 1'b1
          && exp_q.size() > 0)
         check(16'(bword.data_bit), 16'(exp_q.pop_front()), "bit");
      if (mode[1] === 1'b1 && mode === mode_q && rx_bit !== rx_q)
         check(16'(recovered_bit_clock), 16'h0, "data moved on high clock");
      rx_q = rx_bit;
      mode_q = mode;
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      int   i, k, n, per, a, b, k0, k1;
      logic s, d;
      logic hist[64];
      {rst_n, slicer, detector, pair, div_c, stall, slow} = 7'h0;
      {ook, learn} = 2'h3;
      {mode, div_a, div_b, tlen} = 12'h0;
      trim = 3'h6;
      n_errors = 0;
      checked = 0;
      fcnt = 0;
      ecnt = 0;
      void'($urandom(32'h6cce68f5));
      repeat (20) @(posedge clk);
      @(negedge clk);
      check(16'({rx_bit, recovered_bit_clock, tflag, learn_o, bypass, bvalid, baccept,
                 trim_o}), 16'h000e, "reset values");
      @(posedge clk);
      rst_n <= 1'b1;
      // raw path from either source, control copies, idle clock and flag
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         ook   <= i[0];
         learn <= i[0];
         trim  <= i[0] ? 3'($urandom) : 3'h6;
         cyc(6);
         for (k = 0; k < 40; k++) begin
            @(posedge clk);
            s = 1'($urandom);
            d = 1'($urandom);
            slicer   <= s;
            detector <= d;
            hist[k] = i[0] ? d : s;
            @(negedge clk);
            if (k >= 3) check(16'(rx_bit), 16'(hist[k-3]), "raw");
            check(16'({recovered_bit_clock, tflag}), 16'h0, "raw clock or flag");
         end
         check(16'({learn_o, bypass}), {14'h0, i[0], i[0]}, "copy");
         check(16'(trim_o), 16'(trim), "trim copy");
      end
      // deglitch vote at one sample per clock, both levels
      @(posedge clk);
      ook <= 1'b0;
      mode <= RBS_DEGLITCH;
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         slicer <= i[0];
         cyc(20);
         glitch(i[0], 4, 1'b0);
         glitch(i[0], 5, 1'b1);
      end
      // recovery across divider codes, with bit period measured
      for (i = 0; i < 5; i++) begin
         a = i % 4;
         b = (i == 4) ? 7 : i;
         per = (a == 0) ? 1 : (a == 1) ? 5 : (a == 2) ? 6 : 8;
         per = per * (1 << b) * (15 + i % 2);
         @(posedge clk);
         mode   <= RBS_RAW;
         slicer <= 1'b0;
         div_a  <= 2'(a);
         div_b  <= 3'(b);
         div_c  <= 1'(i % 2);
         slow   <= 1'(i % 2);
         cyc(20);
         mode <= RBS_RECOVER;
         fork
            for (k = 0; k < 8; k++)
               send_bit(k == 0 ? 1'b1 : 1'($urandom), per, 1'b1);
            begin
               wait_lvl(1'b1, 4 * per, k0);
               wait_lvl(1'b0, 4 * per, k0);
               wait_lvl(1'b1, 4 * per, k1);
               check(16'(k0 + k1), 16'(per), "bit clock period");
            end
         join
         cyc(3 * per);
         check(16'(exp_q.size()), 16'h0, "bits missing");
      end
      // stalled host: buffer fills, refuses, then drains in order
      @(posedge clk);
      {div_a, div_b, div_c, slow} <= 7'h0;
      mode   <= RBS_RAW;
      stall  <= 1'b1;
      slicer <= 1'b0;
      cyc(20);
      mode <= RBS_RECOVER;
      exp_q = '{1'b1, 1'b0};
      for (k = 0; k < 5; k++) send_bit(k != 1 && k != 4, 15, 1'b0);
      check(16'({bvalid, baccept}), 16'h2, "buffer full");
      stall <= 1'b0;
      cyc(30);
      check(16'(exp_q.size()), 16'h0, "buffer not drained");
      // self train: short and long preambles of single and paired bits
      learn <= 1'b1;
      div_c <= 1'b1;
      tlen  <= 5'h1;
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         mode   <= RBS_RAW;
         slicer <= 1'b0;
         pair   <= i[0];
         cyc(20);
         mode <= RBS_TRAIN;
         fcnt = 0;
         ecnt = 0;
         n = i[1] ? 12 : 4;
         for (k = 0; k < n; k++)
            send_bit(i[0] ? ~k[1] : ~k[0], 16, 1'b0);
         for (k = 0; k < 6; k++) send_bit(1'b0, 16, 1'b0);
         check(16'(fcnt), i[1] ? 16'd16 : 16'h0, "flag");
         check(16'(ecnt), i[1] ? 16'h1 : 16'h0, "end mark");
      end
      tally_and_finish();
   end
endmodule : rx_bit_synchronizer_tb
